// file: bench/testbench.sv
/*
 * self-checking bench: APB tasks note expected reads, a monitor compares them.
 * assumes the tfc_timer top and its bound checker.
 */
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [tfc_pkg::ADDR_W-1:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic cpu_irq_mask = 1'b1;
	logic halt_mode = 1'b0;
	logic cap1 = 1'b0;
	logic cap2 = 1'b0;
	logic [31:0] prdata;
	logic pready, pslverr, pin1, pin2, oe1, oe2, timer_irq;
	logic [33:0] notes[$];
	logic [33:0] note;
	logic [15:0] k;
	logic [15:0] c;
	int errors = 0;
	int total_checks = 0;
	int n;
	int dv;

	always #5 clk = ~clk;

	tfc_timer u_dut (
		.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cpu_irq_mask(cpu_irq_mask), .halt_mode(halt_mode),
		.capture_one_pin(cap1), .capture_two_pin(cap2), .compare_pin_1(pin1),
		.compare_pin_2(pin2), .compare_pin_1_oe(oe1), .compare_pin_2_oe(oe2),
		.timer_irq(timer_irq)
	);
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic close_out;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// note is {check data, expected error, expected data}
	task automatic xfer(input logic wr_en, input logic [7:0] a, input logic [7:0] d,
		input logic [33:0] nt);
		int w;
		@(posedge clk);
		notes.push_back(nt);
		psel <= 1'b1;
		pwrite <= wr_en;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		w = 0;
		do
		begin
			@(posedge clk);
			w++;
		end
		while (pready !== 1'b1 && w < 20);
		if (w >= 20)
			errors++;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		xfer(1'b0, a, 8'h00, {2'b10, 24'h0, e});
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		xfer(1'b1, a, d, 34'h0);
	endtask

	task automatic wait_for(input logic irq_sel, input logic lvl, input int lim);
		n = 0;
		while ((irq_sel ? timer_irq : pin1) !== lvl && n < lim)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= lim)
			errors++;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk)
	begin
		if (pready === 1'b1 && notes.size() > 0)
		begin
			note = notes.pop_front();
			check("pslverr", pslverr, note[32]);
			if (note[33])
				check("prdata", prdata, note[31:0]);
		end
	end

	initial
	begin
		#3000000;
		errors++;
		close_out();
	end
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		void'($urandom(22969));
		k = {8'h01, 8'($urandom_range(254, 1))};
		c = k + 16'h0001;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		// overflow from the reset count at divide by two
		cpu_irq_mask <= 1'b0;
		wr(tfc_pkg::ADDR_CONTROL_ONE, 8'h01);
		wait_for(1'b1, 1'b1, 140000);
		check("ovf irq", timer_irq, 1'b1);
		cpu_irq_mask <= 1'b1;
		repeat (3) @(posedge clk);
		check("irq masked", timer_irq, 1'b0);
		cpu_irq_mask <= 1'b0;
		repeat (3) @(posedge clk);
		check("irq pending", timer_irq, 1'b1);
		rd(tfc_pkg::ADDR_STATUS, 8'h68);
		xfer(1'b0, tfc_pkg::ADDR_ALT_LO, 8'h00, 34'h0);
		rd(tfc_pkg::ADDR_STATUS, 8'h68);
		xfer(1'b0, tfc_pkg::ADDR_CNT_LO, 8'h00, 34'h0);
		rd(tfc_pkg::ADDR_STATUS, 8'h48);
		rd(tfc_pkg::ADDR_CMP1_HI, 8'h80);
		rd(tfc_pkg::ADDR_CMP1_LO, 8'h00);
		rd(tfc_pkg::ADDR_STATUS, 8'h08);
		wr(tfc_pkg::ADDR_CMP2_LO, 8'h00);
		rd(tfc_pkg::ADDR_STATUS, 8'h00);
		check("irq cleared", timer_irq, 1'b0);
		// both channels match a random value at divide by eight, then halt
		wr(tfc_pkg::ADDR_CMP1_HI, k[15:8]);
		wr(tfc_pkg::ADDR_CMP1_LO, k[7:0]);
		wr(tfc_pkg::ADDR_CMP2_HI, k[15:8]);
		wr(tfc_pkg::ADDR_CMP2_LO, k[7:0]);
		rd(tfc_pkg::ADDR_CMP2_LO, k[7:0]);
		wr(tfc_pkg::ADDR_CONTROL_ONE, 8'h1A);
		wr(tfc_pkg::ADDR_CONTROL_TWO, 8'h0E);
		wr(tfc_pkg::ADDR_CNT_HI, 8'h00);
		wait_for(1'b0, 1'b1, 4300);
		halt_mode <= 1'b1;
		repeat (2) @(posedge clk);
		check("pins", {pin1, pin2}, 2'b11);
		check("oe", {oe1, oe2}, 2'b11);
		check("cmp irq", timer_irq, 1'b1);
		cap1 <= 1'b1;
		cap2 <= 1'b1;
		repeat (6) @(posedge clk);
		cap1 <= 1'b0;
		cap2 <= 1'b0;
		rd(tfc_pkg::ADDR_CAP1_HI, c[15:8]);
		rd(tfc_pkg::ADDR_STATUS, 8'h58);
		xfer(1'b0, tfc_pkg::ADDR_CAP2_LO, 8'h00, 34'h0);
		rd(tfc_pkg::ADDR_STATUS, 8'h48);
		// buffered low byte survives a running counter and a second high read
		rd(tfc_pkg::ADDR_CNT_HI, c[15:8]);
		halt_mode <= 1'b0;
		repeat (40) @(posedge clk);
		xfer(1'b0, tfc_pkg::ADDR_CNT_HI, 8'h00, 34'h0);
		rd(tfc_pkg::ADDR_CNT_LO, c[7:0]);
		halt_mode <= 1'b1;
		wr(tfc_pkg::ADDR_CNT_HI, 8'h00);
		rd(tfc_pkg::ADDR_CNT_LO, 8'h00);
		rd(tfc_pkg::ADDR_ALT_HI, 8'h00);
		halt_mode <= 1'b0;
		repeat (40) @(posedge clk);
		rd(tfc_pkg::ADDR_ALT_LO, 8'h00);
		wr(tfc_pkg::ADDR_STATUS, 8'h04);
		repeat (2) @(posedge clk);
		check("oe off", {oe1, oe2}, 2'b00);
		rd(tfc_pkg::ADDR_STATUS, 8'h4C);
		wr(tfc_pkg::ADDR_STATUS, 8'h00);
		xfer(1'b0, 8'h3C, 8'h00, {2'b01, 32'h0});
		xfer(1'b1, 8'h40, 8'h5A, {2'b01, 32'h0});
		// time from counter clear to a match at 32 for each divider code
		wr(tfc_pkg::ADDR_CMP1_HI, 8'h00);
		wr(tfc_pkg::ADDR_CMP1_LO, 8'h20);
		for (int i = 0; i < 4; i++)
		begin
			dv = (i == 0) ? 2 : (i == 1) ? 4 : 8;
			halt_mode <= 1'b1;
			wr(tfc_pkg::ADDR_CONTROL_ONE, {4'h0, i[0], 3'b000});
			wr(tfc_pkg::ADDR_CONTROL_TWO, {6'h01, i[1:0]});
			wr(tfc_pkg::ADDR_CNT_HI, 8'h00);
			halt_mode <= 1'b0;
			wait_for(1'b0, i[0], 400);
			check("div span", (n >= 32 * dv && n <= 35 * dv), 1'b1);
		end
		close_out();
	end
endmodule // testbench

`default_nettype wire

// file: bench/tfc_timer_sva.sv
/*
 * checker bound to the timer top: APB answer, compare pins and interrupt.
 * assumes the tfc_timer port list and a single clock domain.
 */
`default_nettype none

module tfc_timer_sva (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [tfc_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic cpu_irq_mask,
	input wire logic halt_mode,
	input wire logic compare_pin_1,
	input wire logic compare_pin_2,
	input wire logic compare_pin_1_oe,
	input wire logic compare_pin_2_oe,
	input wire logic timer_irq
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////////////////
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence done_s;
		psel && penable && pready;
	endsequence
	////////////////////////////////////////////////////////////////////////////////
	ready_after_setup_a: assert property (setup_s |=> pready)
		else $error("no ready after setup");
	ready_single_a: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	error_with_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	status_reserved_a:
		assert property ((done_s ##0 (!pwrite && paddr == tfc_pkg::ADDR_STATUS))
			|-> prdata[1:0] == 2'b00) else $error("reserved status bits set");
	disable_oe_a:
		assert property ((done_s ##0 (pwrite && paddr == tfc_pkg::ADDR_STATUS && pwdata[2]))
			|-> ##[1:2] !(compare_pin_1_oe || compare_pin_2_oe))
			else $error("outputs kept while disabled");
	irq_masked_a: assert property (cpu_irq_mask |=> !timer_irq)
		else $error("interrupt while masked");
	pin_reset_a:
		assert property (disable iff (1'b0) rst |=> !(compare_pin_1 || compare_pin_2))
			else $error("compare pin high in reset");
	halt_pin_a:
		assert property (halt_mode [*3] |-> $stable(compare_pin_1) && $stable(compare_pin_2))
			else $error("compare pin moved in halt");
endmodule // tfc_timer_sva

bind tfc_timer tfc_timer_sva u_sva (
	.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.cpu_irq_mask(cpu_irq_mask), .halt_mode(halt_mode), .compare_pin_1(compare_pin_1),
	.compare_pin_2(compare_pin_2), .compare_pin_1_oe(compare_pin_1_oe),
	.compare_pin_2_oe(compare_pin_2_oe), .timer_irq(timer_irq)
);

`default_nettype wire

// file: hw/tfc_compare.sv
/*
 * one output compare channel: match pulse and pin latch.
 * assumes tick and count from the shared timer interface.
 */
`default_nettype none

module tfc_compare (
	input wire logic clk,
	input wire logic rst,
	tfc_tick_if.snk tb,
	input wire logic [tfc_pkg::CNT_W-1:0] value,
	input wire logic level,
	input wire logic enable,
	output logic match,
	output logic pin
);
	assign match = tb.tick && (tb.count == value);

	// latch is cleared by reset, then follows the programmed level on a match while enable is set
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			pin <= 1'b0;
		else if (match && enable)
			pin <= level;
	end
endmodule // tfc_compare

`default_nettype wire

// file: hw/tfc_pkg.sv
/*
 * constants for the free running timer with two compare channels.
 * assumes an APB slave with 32-bit data; one register per aligned word.
 */
`default_nettype none

package tfc_pkg;
	localparam int CNT_W = 16;
	localparam int BYTE_W = 8;
	localparam int ADDR_W = 8;

	// register byte addresses
	localparam logic [ADDR_W-1:0] ADDR_CONTROL_ONE = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_CONTROL_TWO = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_CNT_HI = 8'h0C;
	localparam logic [ADDR_W-1:0] ADDR_CNT_LO = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_ALT_HI = 8'h14;
	localparam logic [ADDR_W-1:0] ADDR_ALT_LO = 8'h18;
	localparam logic [ADDR_W-1:0] ADDR_CMP1_HI = 8'h1C;
	localparam logic [ADDR_W-1:0] ADDR_CMP1_LO = 8'h20;
	localparam logic [ADDR_W-1:0] ADDR_CMP2_HI = 8'h24;
	localparam logic [ADDR_W-1:0] ADDR_CMP2_LO = 8'h28;
	localparam logic [ADDR_W-1:0] ADDR_CAP1_HI = 8'h2C;
	localparam logic [ADDR_W-1:0] ADDR_CAP1_LO = 8'h30;
	localparam logic [ADDR_W-1:0] ADDR_CAP2_HI = 8'h34;
	localparam logic [ADDR_W-1:0] ADDR_CAP2_LO = 8'h38;

	// control_one fields
	localparam int C1_OVF_IE = 0;
	localparam int C1_CMP_IE = 1;
	localparam int C1_CAP_IE = 2;
	localparam int C1_LVL1 = 3;
	localparam int C1_LVL2 = 4;
	localparam logic [4:0] C1_MASK = 5'h1F;
	// control_two fields
	localparam int C2_DIV_LSB = 0;
	localparam int C2_OE1 = 2;
	localparam int C2_OE2 = 3;
	localparam logic [3:0] C2_MASK = 4'hF;
	// status fields
	localparam int ST_CMP1 = 6;
	localparam int ST_OVF = 5;
	localparam int ST_CAP2 = 4;
	localparam int ST_CMP2 = 3;
	localparam int ST_DIS = 2;

	localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
	localparam logic [CNT_W-1:0] CMP_RESET = 16'h8000;

	typedef enum logic [1:0] {
		TFC_DIV2 = 2'b00,
		TFC_DIV4 = 2'b01,
		TFC_DIV8 = 2'b10,
		TFC_DIV8B = 2'b11
	} tfc_div_e;
endpackage

`default_nettype wire

// file: hw/tfc_prescaler.sv
/*
 * prescaler: one-cycle timer clock enable every 2, 4 or 8 cpu clocks.
 * assumes the top drives count on the same interface.
 */
`default_nettype none

module tfc_prescaler (
	input wire logic clk,
	input wire logic rst,
	input wire logic run,
	input wire tfc_pkg::tfc_div_e div_sel,
	tfc_tick_if.src tb
);
	logic [2:0] pre_reg;
	logic [2:0] last;

	always_comb
	begin
		case (div_sel)
			tfc_pkg::TFC_DIV2: last = 3'h1;
			tfc_pkg::TFC_DIV4: last = 3'h3;
			default: last = 3'h7;
		endcase
	end

	// frozen while disabled or halted
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			pre_reg <= 3'h0;
		else if (run)
			pre_reg <= (pre_reg >= last) ? 3'h0 : pre_reg + 3'h1;
	end

	assign tb.tick = run && (pre_reg >= last);
endmodule // tfc_prescaler

`default_nettype wire

// file: hw/tfc_tick_if.sv
/*
 * timer clock enable and count value shared by the timer's own modules.
 * assumes one clock domain.
 */
`default_nettype none

interface tfc_tick_if;
	logic tick;
	logic [tfc_pkg::CNT_W-1:0] count;
	modport src (output tick, output count);
	modport snk (input tick, input count);
endinterface

`default_nettype wire

// file: hw/tfc_timer.sv
/*
 * free running 16-bit timer with buffered counter reads, overflow flag,
 * two output compare channels and two capture inputs, on an APB slave.
 * assumes capture pins are asynchronous; irq mask and halt come from the cpu.
 */
`default_nettype none

module tfc_timer (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [tfc_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cpu_irq_mask,
	input wire logic halt_mode,
	input wire logic capture_one_pin,
	input wire logic capture_two_pin,
	output logic compare_pin_1,
	output logic compare_pin_2,
	output logic compare_pin_1_oe,
	output logic compare_pin_2_oe,
	output logic timer_irq
);
	localparam int W = tfc_pkg::CNT_W;
	localparam int B = tfc_pkg::BYTE_W;

	logic [4:0] control_one_reg;
	logic [3:0] control_two_reg;
	logic timer_disable_reg;
	logic overflow_flag_reg;
	logic compare_one_flag_reg;
	logic compare_two_flag_reg;
	logic capture_two_flag_reg;
	logic arm_ovf_reg;
	logic arm_cmp1_reg;
	logic arm_cmp2_reg;
	logic arm_cap2_reg;
	logic [W-1:0] cnt_reg;
	logic [W-1:0] compare_one_value_reg;
	logic [W-1:0] compare_two_value_reg;
	logic [W-1:0] capture_one_reg;
	logic [W-1:0] capture_two_reg;
	logic [B-1:0] cnt_buf_reg;
	logic cnt_buf_full_reg;
	logic [B-1:0] alt_buf_reg;
	logic alt_buf_full_reg;
	logic [B-1:0] cap1_buf_reg;
	logic [2:0] cap1_sync_reg;
	logic [2:0] cap2_sync_reg;
	logic [31:0] rdata_next;
	logic hit_next;
	logic run;
	logic match_one;
	logic match_two;
	logic cap1_edge;
	logic cap2_edge;
	logic done;
	logic rd_done;
	logic wr_done;
	logic [B-1:0] wbyte;
	logic [7:0] status_value;

	tfc_tick_if tbus ();

	////////////////////////////////////////////////////////////////////////////
	// timer clock and counter

	assign run = !timer_disable_reg && !halt_mode;
	assign tbus.count = cnt_reg;

	tfc_prescaler u_pre (
		.clk(clk),
		.rst(rst),
		.run(run),
		.div_sel(tfc_pkg::tfc_div_e'(control_two_reg[tfc_pkg::C2_DIV_LSB +: 2])),
		.tb(tbus.src)
	);

	// halt only gates counting, so the held value carries on afterwards
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			cnt_reg <= tfc_pkg::CNT_RESET;
		else if (wr_done && (paddr == tfc_pkg::ADDR_CNT_LO || paddr == tfc_pkg::ADDR_CNT_HI))
			cnt_reg <= tfc_pkg::CNT_RESET;
		else if (tbus.tick)
			cnt_reg <= cnt_reg + 16'h0001;
	end

	////////////////////////////////////////////////////////////////////////////
	// compare channels

	tfc_compare u_cmp1 (
		.clk(clk),
		.rst(rst),
		.tb(tbus.snk),
		.value(compare_one_value_reg),
		.level(control_one_reg[tfc_pkg::C1_LVL1]),
		.enable(control_two_reg[tfc_pkg::C2_OE1]),
		.match(match_one),
		.pin(compare_pin_1)
	);

	tfc_compare u_cmp2 (
		.clk(clk),
		.rst(rst),
		.tb(tbus.snk),
		.value(compare_two_value_reg),
		.level(control_one_reg[tfc_pkg::C1_LVL2]),
		.enable(control_two_reg[tfc_pkg::C2_OE2]),
		.match(match_two),
		.pin(compare_pin_2)
	);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			compare_pin_1_oe <= 1'b0;
			compare_pin_2_oe <= 1'b0;
		end
		else
		begin
			compare_pin_1_oe <= control_two_reg[tfc_pkg::C2_OE1] && !timer_disable_reg;
			compare_pin_2_oe <= control_two_reg[tfc_pkg::C2_OE2] && !timer_disable_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// capture inputs: two-stage synchronisers, then a rising edge detect

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cap1_sync_reg <= 3'h0;
			cap2_sync_reg <= 3'h0;
		end
		else
		begin
			cap1_sync_reg <= {cap1_sync_reg[1:0], capture_one_pin};
			cap2_sync_reg <= {cap2_sync_reg[1:0], capture_two_pin};
		end
	end

	assign cap1_edge = cap1_sync_reg[1] && !cap1_sync_reg[2];
	assign cap2_edge = cap2_sync_reg[1] && !cap2_sync_reg[2];

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			capture_one_reg <= tfc_pkg::CNT_RESET;
			capture_two_reg <= tfc_pkg::CNT_RESET;
		end
		else
		begin
			if (cap1_edge)
				capture_one_reg <= cnt_reg;
			if (cap2_edge)
				capture_two_reg <= cnt_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// apb slave: data is registered in setup, answer comes one cycle later

	assign done = psel && penable && pready;
	assign rd_done = done && !pwrite;
	assign wr_done = done && pwrite;
	assign wbyte = pwdata[B-1:0];
	assign status_value = {1'b0, compare_one_flag_reg, overflow_flag_reg, capture_two_flag_reg,
		compare_two_flag_reg, timer_disable_reg, 2'b00};

	always_comb
	begin
		rdata_next = 32'h0000_0000;
		hit_next = 1'b1;
		case (paddr)
			tfc_pkg::ADDR_CONTROL_ONE: rdata_next[4:0] = control_one_reg;
			tfc_pkg::ADDR_CONTROL_TWO: rdata_next[3:0] = control_two_reg;
			tfc_pkg::ADDR_STATUS: rdata_next[7:0] = status_value;
			tfc_pkg::ADDR_CNT_HI: rdata_next[B-1:0] = cnt_reg[W-1:B];
			tfc_pkg::ADDR_ALT_HI: rdata_next[B-1:0] = cnt_reg[W-1:B];
			tfc_pkg::ADDR_CNT_LO: rdata_next[B-1:0] = cnt_buf_full_reg ? cnt_buf_reg
				: cnt_reg[B-1:0];
			tfc_pkg::ADDR_ALT_LO: rdata_next[B-1:0] = alt_buf_full_reg ? alt_buf_reg
				: cnt_reg[B-1:0];
			tfc_pkg::ADDR_CMP1_HI: rdata_next[B-1:0] = compare_one_value_reg[W-1:B];
			tfc_pkg::ADDR_CMP1_LO: rdata_next[B-1:0] = compare_one_value_reg[B-1:0];
			tfc_pkg::ADDR_CMP2_HI: rdata_next[B-1:0] = compare_two_value_reg[W-1:B];
			tfc_pkg::ADDR_CMP2_LO: rdata_next[B-1:0] = compare_two_value_reg[B-1:0];
			tfc_pkg::ADDR_CAP1_HI: rdata_next[B-1:0] = capture_one_reg[W-1:B];
			tfc_pkg::ADDR_CAP1_LO: rdata_next[B-1:0] = cap1_buf_reg;
			tfc_pkg::ADDR_CAP2_HI: rdata_next[B-1:0] = capture_two_reg[W-1:B];
			tfc_pkg::ADDR_CAP2_LO: rdata_next[B-1:0] = capture_two_reg[B-1:0];
			default: hit_next = 1'b0;
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel && !penable;
			if (psel && !penable)
			begin
				prdata <= pwrite ? 32'h0000_0000 : rdata_next;
				pslverr <= !hit_next;
			end
			else if (done)
			begin
				prdata <= 32'h0000_0000;
				pslverr <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// software owned registers

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			control_one_reg <= '0;
			control_two_reg <= '0;
			timer_disable_reg <= 1'b0;
			compare_one_value_reg <= tfc_pkg::CMP_RESET;
			compare_two_value_reg <= tfc_pkg::CMP_RESET;
		end
		else if (wr_done)
		begin
			case (paddr)
				tfc_pkg::ADDR_CONTROL_ONE: control_one_reg <= wbyte[4:0] & tfc_pkg::C1_MASK;
				tfc_pkg::ADDR_CONTROL_TWO: control_two_reg <= wbyte[3:0] & tfc_pkg::C2_MASK;
				tfc_pkg::ADDR_STATUS: timer_disable_reg <= wbyte[tfc_pkg::ST_DIS];
				tfc_pkg::ADDR_CMP1_HI: compare_one_value_reg[W-1:B] <= wbyte;
				tfc_pkg::ADDR_CMP1_LO: compare_one_value_reg[B-1:0] <= wbyte;
				tfc_pkg::ADDR_CMP2_HI: compare_two_value_reg[W-1:B] <= wbyte;
				tfc_pkg::ADDR_CMP2_LO: compare_two_value_reg[B-1:0] <= wbyte;
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// low byte holding buffers for the two-byte counter and capture one reads

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cnt_buf_reg <= '0;
			cnt_buf_full_reg <= 1'b0;
			alt_buf_reg <= '0;
			alt_buf_full_reg <= 1'b0;
			cap1_buf_reg <= '0;
		end
		else
		begin
			if (rd_done && paddr == tfc_pkg::ADDR_CNT_HI && !cnt_buf_full_reg)
			begin
				cnt_buf_reg <= cnt_reg[B-1:0];
				cnt_buf_full_reg <= 1'b1;
			end
			else if (rd_done && paddr == tfc_pkg::ADDR_CNT_LO)
				cnt_buf_full_reg <= 1'b0;
			if (rd_done && paddr == tfc_pkg::ADDR_ALT_HI && !alt_buf_full_reg)
			begin
				alt_buf_reg <= cnt_reg[B-1:0];
				alt_buf_full_reg <= 1'b1;
			end
			else if (rd_done && paddr == tfc_pkg::ADDR_ALT_LO)
				alt_buf_full_reg <= 1'b0;
			if (rd_done && paddr == tfc_pkg::ADDR_CAP1_HI)
				cap1_buf_reg <= capture_one_reg[B-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// status flags: a status read while set arms the clear; a new event wins

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			arm_ovf_reg <= 1'b0;
			arm_cmp1_reg <= 1'b0;
			arm_cmp2_reg <= 1'b0;
			arm_cap2_reg <= 1'b0;
		end
		else if (rd_done && paddr == tfc_pkg::ADDR_STATUS)
		begin
			arm_ovf_reg <= overflow_flag_reg;
			arm_cmp1_reg <= compare_one_flag_reg;
			arm_cmp2_reg <= compare_two_flag_reg;
			arm_cap2_reg <= capture_two_flag_reg;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			overflow_flag_reg <= 1'b0;
		else if (tbus.tick && cnt_reg == tfc_pkg::CNT_MAX)
			overflow_flag_reg <= 1'b1;
		else if (done && arm_ovf_reg && paddr == tfc_pkg::ADDR_CNT_LO)
			overflow_flag_reg <= 1'b0;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			compare_one_flag_reg <= 1'b0;
		else if (match_one)
			compare_one_flag_reg <= 1'b1;
		else if (done && arm_cmp1_reg && paddr == tfc_pkg::ADDR_CMP1_LO)
			compare_one_flag_reg <= 1'b0;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			compare_two_flag_reg <= 1'b0;
		else if (match_two)
			compare_two_flag_reg <= 1'b1;
		else if (done && arm_cmp2_reg && paddr == tfc_pkg::ADDR_CMP2_LO)
			compare_two_flag_reg <= 1'b0;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			capture_two_flag_reg <= 1'b0;
		else if (cap2_edge)
			capture_two_flag_reg <= 1'b1;
		else if (done && arm_cap2_reg && paddr == tfc_pkg::ADDR_CAP2_LO)
			capture_two_flag_reg <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// single interrupt line; requests stay pending in the flags while masked

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			timer_irq <= 1'b0;
		else
			timer_irq <= !cpu_irq_mask && (
				(overflow_flag_reg && control_one_reg[tfc_pkg::C1_OVF_IE]) ||
				((compare_one_flag_reg || compare_two_flag_reg)
					&& control_one_reg[tfc_pkg::C1_CMP_IE]) ||
				(capture_two_flag_reg && control_one_reg[tfc_pkg::C1_CAP_IE]));
	end
endmodule // tfc_timer

`default_nettype wire
